// ==== hw/ccm_mode_ctrl.sv ====
// The Avalon-MM register port was chosen for this implementation.
module ccm_mode_ctrl #(
    parameter int unsigned CNT_W = 16
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Avalon-MM slave
    input wire ccm_pkg::ccm_av_req_s i_av_req,
    output logic o_av_waitrequest,
    output logic [ccm_pkg::AV_DATA_W-1:0] o_av_readdata,
    // Timer core, same clock
    input wire logic [CNT_W-1:0] i_timer_count_value,
    input wire logic i_update_event,
    input wire logic i_trigger_event,
    input wire logic i_filtered_external_trigger,
    input wire logic i_internal_trigger_source,
    // Timer input pins, asynchronous
    input wire logic i_timer_input_one,
    input wire logic i_timer_input_two,
    // Towards output stage and capture logic
    output logic o_ch1_output_reference,
    output logic o_ch2_output_reference,
    output logic o_capture_input_one,
    output logic o_capture_input_two,
    output logic [15:0] o_capture_compare_mode_one
);

    // Counter wider than a bus word could not be written in one access
    if (CNT_W < 1 || CNT_W > ccm_pkg::AV_DATA_W) begin : g_cnt_w_check
        $error("CNT_W must lie between 1 and the bus data width");
    end

    localparam int unsigned NCH = 2;

    // Bus handshake state
    logic wait_q;
    logic [ccm_pkg::AV_DATA_W-1:0] rdata_q;
    logic [ccm_pkg::AV_DATA_W-1:0] rd_word;
    logic req_any;
    logic wr_fire;
    logic [5:0] word_addr;

    // Registers
    ccm_pkg::ccm_ch_cfg_s [NCH-1:0] cfg_q;
    logic [NCH-1:0] chen_q;
    logic [1:0] prot_q;
    logic [NCH-1:0][CNT_W-1:0] ccr_pre_q;
    logic [NCH-1:0][CNT_W-1:0] ccr_act_q;
    logic [ccm_pkg::AV_DATA_W-1:0] wmask;

    // Write decode per channel
    logic [NCH-1:0] cfg_wr;
    logic [NCH-1:0] dir_open;
    logic [NCH-1:0] mode_lock;
    logic [NCH-1:0] ccr_sel;
    logic [NCH-1:0][CNT_W-1:0] ccr_wdata;

    // Compare pipeline and references
    logic [NCH-1:0] match_q;
    logic [NCH-1:0] below_q;
    logic [NCH-1:0] above_q;
    logic [NCH-1:0] level;
    logic [NCH-1:0] fast_hit;
    logic [NCH-1:0] hit;
    logic [NCH-1:0] level_prev_q;
    logic [NCH-1:0][2:0] mode_prev_q;
    logic [NCH-1:0] ref_q;

    // Input synchronisers and capture routing
    logic [1:0] ti_meta_q;
    logic [1:0] ti_sync_q;
    logic [NCH-1:0] cap_q;

    assign req_any = i_av_req.read | i_av_req.write;
    assign wr_fire = i_av_req.write & ~wait_q;
    assign word_addr = i_av_req.address[7:2];

    always_comb begin
        for (int b = 0; b < ccm_pkg::AV_BE_W; b++) begin
            wmask[8*b +: 8] = {8{i_av_req.byteenable[b]}};
        end
    end

    // Lock and direction gates judge the settings held before the write lands
    always_comb begin
        cfg_wr = '0;
        dir_open = '0;
        mode_lock = '0;
        ccr_sel = '0;
        ccr_wdata = '0;
        for (int c = 0; c < NCH; c++) begin
            // Lanes two and three of the mode word have no channel behind them
            cfg_wr[c] = wr_fire && word_addr == ccm_pkg::OFF_MODE_ONE[7:2] && i_av_req.byteenable[c];
            dir_open[c] = !chen_q[c];
            mode_lock[c] = (prot_q == ccm_pkg::PROT_LOCK_LEVEL) &&
                           (cfg_q[c].direction_select == ccm_pkg::DIR_OUTPUT);
            ccr_sel[c] = wr_fire && word_addr == (c == 0 ? ccm_pkg::OFF_CH1_COMPARE[7:2]
                                                         : ccm_pkg::OFF_CH2_COMPARE[7:2]);
            ccr_wdata[c] = CNT_W'((i_av_req.writedata & wmask) |
                                  (ccm_pkg::AV_DATA_W'(ccr_pre_q[c]) & ~wmask));
        end
    end

    // One wait cycle per request; released at the edge after it is seen
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(req_any & wait_q);
        end
    end

    always_comb begin
        rd_word = ccm_pkg::RD_UNMAPPED;
        case (word_addr)
            ccm_pkg::OFF_MODE_ONE[7:2]: begin
                rd_word = {16'h0000, cfg_q};
            end
            ccm_pkg::OFF_CHAN_ENABLE[7:2]: begin
                rd_word = {30'h0000_0000, chen_q};
            end
            ccm_pkg::OFF_PROTECT[7:2]: begin
                rd_word = {30'h0000_0000, prot_q};
            end
            ccm_pkg::OFF_CH1_COMPARE[7:2]: begin
                rd_word = ccm_pkg::AV_DATA_W'(ccr_pre_q[0]);
            end
            ccm_pkg::OFF_CH2_COMPARE[7:2]: begin
                rd_word = ccm_pkg::AV_DATA_W'(ccr_pre_q[1]);
            end
            ccm_pkg::OFF_STATUS[7:2]: begin
                rd_word[ccm_pkg::STAT_REF_LSB +: NCH] = ref_q;
                for (int c = 0; c < NCH; c++) begin
                    rd_word[ccm_pkg::STAT_OUT_LSB + c] = (cfg_q[c].direction_select == ccm_pkg::DIR_OUTPUT);
                end
            end
            default: begin
                rd_word = ccm_pkg::RD_UNMAPPED;
            end
        endcase
    end

    // Read data captured in the wait cycle so it stands at the release edge
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rdata_q <= ccm_pkg::RD_UNMAPPED;
        end else if (i_av_req.read && wait_q) begin
            rdata_q <= rd_word;
        end
    end

    // Mode register, one byte lane per channel
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cfg_q <= ccm_pkg::RST_MODE_ONE;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (cfg_wr[c]) begin
                    cfg_q[c].fast_response_enable <=
                        i_av_req.writedata[c*ccm_pkg::CH_CFG_W + 2];
                    cfg_q[c].reference_clear_enable <=
                        i_av_req.writedata[c*ccm_pkg::CH_CFG_W + 7];
                    // Direction is ignored while the channel runs
                    if (dir_open[c]) begin
                        cfg_q[c].direction_select <=
                            i_av_req.writedata[c*ccm_pkg::CH_CFG_W +: 2];
                    end
                    if (!mode_lock[c]) begin
                        cfg_q[c].compare_preload_enable <=
                            i_av_req.writedata[c*ccm_pkg::CH_CFG_W + 3];
                        cfg_q[c].compare_mode <=
                            i_av_req.writedata[c*ccm_pkg::CH_CFG_W + 4 +: 3];
                    end
                end
            end
        end
    end

    // Channel enables and protection level
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            chen_q <= ccm_pkg::RST_CHAN_ENABLE;
            prot_q <= ccm_pkg::RST_PROTECT;
        end else if (wr_fire && i_av_req.byteenable[0]) begin
            if (word_addr == ccm_pkg::OFF_CHAN_ENABLE[7:2]) begin
                chen_q[0] <= i_av_req.writedata[ccm_pkg::CHEN_CH1_BIT];
                chen_q[1] <= i_av_req.writedata[ccm_pkg::CHEN_CH2_BIT];
            end
            if (word_addr == ccm_pkg::OFF_PROTECT[7:2]) begin
                prot_q <= i_av_req.writedata[ccm_pkg::PROT_LSB +: 2];
            end
        end
    end

    // Compare values: written stage plus active stage
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            for (int c = 0; c < NCH; c++) begin
                ccr_pre_q[c] <= ccm_pkg::RST_COMPARE[CNT_W-1:0];
                ccr_act_q[c] <= ccm_pkg::RST_COMPARE[CNT_W-1:0];
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (ccr_sel[c]) begin
                    ccr_pre_q[c] <= ccr_wdata[c];
                    if (!cfg_q[c].compare_preload_enable) begin
                        ccr_act_q[c] <= ccr_wdata[c];
                    end
                end else if (cfg_q[c].compare_preload_enable && i_update_event) begin
                    ccr_act_q[c] <= ccr_pre_q[c];
                end
            end
        end
    end

    // Comparison stage; one cycle of latency that fast response bypasses
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            match_q <= '0;
            below_q <= '0;
            above_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                // All three outcomes kept so a mode change never sees a stale comparison
                match_q[c] <= (i_timer_count_value == ccr_act_q[c]);
                below_q[c] <= (i_timer_count_value < ccr_act_q[c]);
                above_q[c] <= (i_timer_count_value > ccr_act_q[c]);
            end
        end
    end

    always_comb begin
        fast_hit = '0;
        hit = '0;
        level = '0;
        for (int c = 0; c < NCH; c++) begin
            // Fast response treats a trigger as an immediate match
            fast_hit[c] = cfg_q[c].fast_response_enable & i_trigger_event;
            hit[c] = match_q[c] | fast_hit[c];
            if (cfg_q[c].compare_mode == ccm_pkg::MODE_PWM_ONE) begin
                level[c] = below_q[c];
            end else begin
                level[c] = above_q[c];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            level_prev_q <= '0;
            mode_prev_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                level_prev_q[c] <= level[c];
                mode_prev_q[c] <= cfg_q[c].compare_mode;
            end
        end
    end

    // Output references
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ref_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (cfg_q[c].reference_clear_enable && i_filtered_external_trigger) begin
                    ref_q[c] <= 1'b0;
                end else if (cfg_q[c].direction_select != ccm_pkg::DIR_OUTPUT) begin
                    ref_q[c] <= ref_q[c];
                end else begin
                    case (cfg_q[c].compare_mode)
                        ccm_pkg::MODE_FREEZE: begin
                            ref_q[c] <= ref_q[c];
                        end
                        ccm_pkg::MODE_SET_ON_MATCH: begin
                            if (hit[c]) begin
                                ref_q[c] <= 1'b1;
                            end
                        end
                        ccm_pkg::MODE_CLEAR_ON_MATCH: begin
                            if (hit[c]) begin
                                ref_q[c] <= 1'b0;
                            end
                        end
                        ccm_pkg::MODE_TOGGLE_ON_MATCH: begin
                            if (hit[c]) begin
                                ref_q[c] <= ~ref_q[c];
                            end
                        end
                        ccm_pkg::MODE_FORCE_LOW: begin
                            ref_q[c] <= 1'b0;
                        end
                        ccm_pkg::MODE_FORCE_HIGH: begin
                            ref_q[c] <= 1'b1;
                        end
                        ccm_pkg::MODE_PWM_ONE, ccm_pkg::MODE_PWM_TWO: begin
                            // Both PWM levels are low at the match point
                            if (fast_hit[c]) begin
                                ref_q[c] <= 1'b0;
                            end else if (level[c] != level_prev_q[c] ||
                                         mode_prev_q[c] == ccm_pkg::MODE_FREEZE) begin
                                ref_q[c] <= level[c];
                            end
                        end
                        default: begin
                            ref_q[c] <= ref_q[c];
                        end
                    endcase
                end
            end
        end
    end

    // Timer input pins come from outside the clock domain
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ti_meta_q <= '0;
            ti_sync_q <= '0;
        end else begin
            ti_meta_q <= {i_timer_input_two, i_timer_input_one};
            ti_sync_q <= ti_meta_q;
        end
    end

    // Capture input routing; channel 2 sees the inputs swapped
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cap_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                case (cfg_q[c].direction_select)
                    ccm_pkg::DIR_OWN_INPUT: begin
                        cap_q[c] <= ti_sync_q[c];
                    end
                    ccm_pkg::DIR_OTHER_INPUT: begin
                        cap_q[c] <= ti_sync_q[1-c];
                    end
                    ccm_pkg::DIR_INTERNAL_TRIG: begin
                        cap_q[c] <= i_internal_trigger_source;
                    end
                    default: begin
                        cap_q[c] <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign o_av_waitrequest = wait_q;
    assign o_av_readdata = rdata_q;
    assign o_ch1_output_reference = ref_q[0];
    assign o_ch2_output_reference = ref_q[1];
    assign o_capture_input_one = cap_q[0];
    assign o_capture_input_two = cap_q[1];
    assign o_capture_compare_mode_one = cfg_q;

endmodule // ccm_mode_ctrl

// ==== hw/ccm_pkg.sv ====
package ccm_pkg;

    // Avalon-MM slave geometry
    localparam int unsigned AV_ADDR_W = 8;
    localparam int unsigned AV_DATA_W = 32;
    localparam int unsigned AV_BE_W = 4;

    // Register byte offsets
    localparam logic [7:0] OFF_MODE_ONE = 8'h18;
    localparam logic [7:0] OFF_CHAN_ENABLE = 8'h20;
    localparam logic [7:0] OFF_PROTECT = 8'h24;
    localparam logic [7:0] OFF_CH1_COMPARE = 8'h34;
    localparam logic [7:0] OFF_CH2_COMPARE = 8'h38;
    localparam logic [7:0] OFF_STATUS = 8'h40;

    // Reset values
    localparam logic [15:0] RST_MODE_ONE = 16'h0000;
    localparam logic [1:0] RST_CHAN_ENABLE = 2'h0;
    localparam logic [1:0] RST_PROTECT = 2'h0;
    localparam logic [31:0] RST_COMPARE = 32'h0000_0000;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // Field positions inside the enable, protect and status words; per-channel field width in the mode word
    localparam int unsigned CHEN_CH1_BIT = 0;
    localparam int unsigned CHEN_CH2_BIT = 1;
    localparam int unsigned PROT_LSB = 0;
    localparam int unsigned STAT_REF_LSB = 0;
    localparam int unsigned STAT_OUT_LSB = 4;
    localparam int unsigned CH_CFG_W = 8;

    // Protection level that locks output-mode compare settings
    localparam logic [1:0] PROT_LOCK_LEVEL = 2'h3;

    // Direction encodings (channel 2 swaps the two timer inputs)
    localparam logic [1:0] DIR_OUTPUT = 2'h0;
    localparam logic [1:0] DIR_OWN_INPUT = 2'h1;
    localparam logic [1:0] DIR_OTHER_INPUT = 2'h2;
    localparam logic [1:0] DIR_INTERNAL_TRIG = 2'h3;

    // Compare mode encodings
    localparam logic [2:0] MODE_FREEZE = 3'h0;
    localparam logic [2:0] MODE_SET_ON_MATCH = 3'h1;
    localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
    localparam logic [2:0] MODE_TOGGLE_ON_MATCH = 3'h3;
    localparam logic [2:0] MODE_FORCE_LOW = 3'h4;
    localparam logic [2:0] MODE_FORCE_HIGH = 3'h5;
    localparam logic [2:0] MODE_PWM_ONE = 3'h6;
    localparam logic [2:0] MODE_PWM_TWO = 3'h7;

    // One byte of the mode register, output-compare view
    typedef struct packed {
        logic reference_clear_enable;
        logic [2:0] compare_mode;
        logic compare_preload_enable;
        logic fast_response_enable;
        logic [1:0] direction_select;
    } ccm_ch_cfg_s;

    typedef struct packed {
        logic read;
        logic write;
        logic [AV_ADDR_W-1:0] address;
        logic [AV_BE_W-1:0] byteenable;
        logic [AV_DATA_W-1:0] writedata;
    } ccm_av_req_s;

endpackage

// ==== tb/ccm_mode_ctrl_properties.sv ====
module ccm_mode_ctrl_chk (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Bus and trigger
    input wire ccm_pkg::ccm_av_req_s i_av_req,
    input wire logic o_av_waitrequest,
    input wire logic i_filtered_external_trigger,
    // Watched outputs
    input wire logic o_ch1_output_reference,
    input wire logic o_ch2_output_reference,
    input wire logic o_capture_input_one,
    input wire logic [15:0] o_capture_compare_mode_one
);
    logic [7:0] c1;
    logic [7:0] c2;
    logic clr1;
    assign c1 = o_capture_compare_mode_one[7:0];
    assign c2 = o_capture_compare_mode_one[15:8];
    assign clr1 = c1[7] & i_filtered_external_trigger;
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    chk_reset_clean: assert property (
        $rose(i_rst_n) |-> o_capture_compare_mode_one == 16'h0000 && !o_ch1_output_reference
            && !o_ch2_output_reference) else $error("state not clear after reset");
    chk_clear_ch1: assert property (clr1 |=> !o_ch1_output_reference)
        else $error("ch1 reference not cleared by trigger");
    chk_clear_ch2: assert property (
        c2[7] && i_filtered_external_trigger |=> !o_ch2_output_reference)
        else $error("ch2 reference not cleared by trigger");
    chk_force_low: assert property (
        (c1[6:4] == 3'h4 && c1[1:0] == 2'h0)[*2] |=> !o_ch1_output_reference)
        else $error("forced low mode shows high");
    chk_force_high: assert property (
        (c1[6:4] == 3'h5 && c1[1:0] == 2'h0 && !clr1)[*2] |=> o_ch1_output_reference)
        else $error("forced high mode shows low");
    chk_freeze_holds: assert property (
        (c1[6:4] == 3'h0 && !clr1)[*2] |=> $stable(o_ch1_output_reference))
        else $error("reference moved in freeze mode");
    chk_input_holds: assert property (
        (c1[1:0] != 2'h0 && !clr1)[*2] |=> $stable(o_ch1_output_reference))
        else $error("reference moved while channel is input");
    chk_output_no_capture: assert property (
        (c1[1:0] == 2'h0)[*2] |=> !o_capture_input_one) else $error("capture active on output channel");
    chk_mode_by_write: assert property (
        $changed(o_capture_compare_mode_one) |-> !$past(i_rst_n) || ($past(i_av_req.write)
            && !$past(o_av_waitrequest) && $past(i_av_req.address[7:2]) == 6'h06))
        else $error("mode register changed without write");
endmodule // ccm_mode_ctrl_chk

bind ccm_mode_ctrl ccm_mode_ctrl_chk ccm_mode_ctrl_chk_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_av_req(i_av_req), .o_av_waitrequest(o_av_waitrequest),
    .i_filtered_external_trigger(i_filtered_external_trigger),
    .o_ch1_output_reference(o_ch1_output_reference), .o_ch2_output_reference(o_ch2_output_reference),
    .o_capture_input_one(o_capture_input_one), .o_capture_compare_mode_one(o_capture_compare_mode_one));

// ==== tb/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ccm_pkg::ccm_av_req_s req = '0;
    logic wreq;
    logic [31:0] rdata;
    logic [31:0] rd;
    logic [15:0] cnt = 16'h0000;
    logic upd = 1'b0;
    logic trg = 1'b0;
    logic ext = 1'b0;
    logic its = 1'b0;
    logic ti1 = 1'b0;
    logic ti2 = 1'b0;
    logic [1:0] ref_o;
    logic [1:0] cap;
    logic [15:0] mode;
    logic [7:0] offs [6] = '{8'h18, 8'h20, 8'h24, 8'h34, 8'h38, 8'h7C};
    int err_count = 0;
    int check_count = 0;
    always #20 clk = ~clk;

    ccm_mode_ctrl ccm_mode_ctrl_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_av_req(req),
        .o_av_waitrequest(wreq), .o_av_readdata(rdata), .i_timer_count_value(cnt), .i_update_event(upd),
        .i_trigger_event(trg), .i_filtered_external_trigger(ext), .i_internal_trigger_source(its),
        .i_timer_input_one(ti1), .i_timer_input_two(ti2), .o_ch1_output_reference(ref_o[0]),
        .o_ch2_output_reference(ref_o[1]), .o_capture_input_one(cap[0]), .o_capture_input_two(cap[1]),
        .o_capture_compare_mode_one(mode));

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Request held until the edge that sees waitrequest low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        int n;
        n = 0;
        req.read <= !wr;
        req.write <= wr;
        req.address <= a;
        req.byteenable <= be;
        req.writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        rd = rdata;
        if (n >= 20) begin
            err_count++;
            final_report();
        end
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, 4'b1111, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 4'b1111, 32'h0000_0000);
        cmp($sformatf("register %h", a), exp, rd);
    endtask

    // Flags: bit 1 trigger pulse, bit 0 count shown for one cycle only
    task automatic step(input int ch, input logic [7:0] cfg, input logic [15:0] c, input logic [1:0] f,
                        input logic x, input logic e);
        if (mode[8*ch +: 8] !== cfg) xfer(1'b1, 8'h18, 4'b0011, 32'(cfg) << (8 * ch));
        cnt <= c;
        ext <= x;
        trg <= f[1];
        @(posedge clk);
        trg <= 1'b0;
        if (f[0]) cnt <= c + 16'h0001;
        repeat (4) @(posedge clk);
        cmp($sformatf("reference %0d", ch), {31'h0, e}, 32'(ref_o[ch]));
    endtask

    task automatic capt(input logic [1:0] d);
        logic [3:0] s1;
        logic [3:0] s2;
        wr(8'h18, {16'h0000, 6'h00, d, 6'h00, d});
        for (int p = 0; p < 8; p++) begin
            ti1 <= p[0];
            ti2 <= p[1];
            its <= p[2];
            s1 = {p[2], p[1], p[0], 1'b0};
            s2 = {p[2], p[0], p[1], 1'b0};
            repeat (5) @(posedge clk);
            cmp("capture one", 32'(s1[d]), 32'(cap[0]));
            cmp("capture two", 32'(s2[d]), 32'(cap[1]));
        end
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cmp("mode port", 32'h0000_0000, {16'h0000, mode});
        foreach (offs[i]) rchk(offs[i], 32'h0000_0000);
        rchk(8'h40, 32'h0000_0030);
        wr(8'h7C, 32'hFFFF_FFFF);
        rchk(8'h7C, 32'h0000_0000);
        xfer(1'b1, 8'h18, 4'b0011, 32'h0000_A5C3);
        rchk(8'h18, 32'h0000_A5C3);
        xfer(1'b1, 8'h18, 4'b0001, 32'h0000_1234);
        rchk(8'h18, 32'h0000_A534);
        wr(8'h18, 32'hFFFF_0000);
        rchk(8'h18, 32'h0000_0000);
        wr(8'h20, 32'h0000_0003);
        wr(8'h18, 32'h0000_F3F3);
        rchk(8'h18, 32'h0000_F0F0);
        wr(8'h20, 32'h0000_0001);
        wr(8'h18, 32'h0000_0102);
        rchk(8'h18, 32'h0000_0100);
        wr(8'h20, 32'h0000_0000);
        wr(8'h24, 32'h0000_0003);
        wr(8'h18, 32'h0000_FCFC);
        rchk(8'h18, 32'h0000_FC84);
        wr(8'h24, 32'h0000_0000);
        for (int d = 0; d < 4; d++) capt(d[1:0]);
        rchk(8'h40, 32'h0000_0000);
        wr(8'h18, 32'h0000_0000);
        for (int ch = 0; ch < 2; ch++) begin
            wr(8'(8'h34 + 4 * ch), 32'h0000_000A);
            step(ch, 8'h50, 16'h0005, 2'h0, 1'b0, 1'b1);
            step(ch, 8'h40, 16'h0005, 2'h0, 1'b0, 1'b0);
            step(ch, 8'h10, 16'h0005, 2'h0, 1'b0, 1'b0);
            step(ch, 8'h10, 16'h000A, 2'h1, 1'b0, 1'b1);
            step(ch, 8'h20, 16'h0005, 2'h0, 1'b0, 1'b1);
            step(ch, 8'h20, 16'h000A, 2'h1, 1'b0, 1'b0);
            step(ch, 8'h30, 16'h000A, 2'h1, 1'b0, 1'b1);
            step(ch, 8'h30, 16'h000A, 2'h1, 1'b0, 1'b0);
            step(ch, 8'h30, 16'h000A, 2'h1, 1'b0, 1'b1);
            step(ch, 8'h00, 16'h000A, 2'h1, 1'b0, 1'b1);
            step(ch, 8'h68, 16'h0005, 2'h0, 1'b0, 1'b1);
            step(ch, 8'h68, 16'h000C, 2'h0, 1'b0, 1'b0);
            step(ch, 8'h68, 16'h000A, 2'h0, 1'b0, 1'b0);
            step(ch, 8'h68, 16'h0009, 2'h0, 1'b0, 1'b1);
            step(ch, 8'h00, 16'h0009, 2'h0, 1'b0, 1'b1);
            step(ch, 8'h78, 16'h000C, 2'h0, 1'b0, 1'b1);
            step(ch, 8'h78, 16'h000A, 2'h0, 1'b0, 1'b0);
            step(ch, 8'h78, 16'h000B, 2'h0, 1'b0, 1'b1);
            step(ch, 8'hD0, 16'h0005, 2'h0, 1'b1, 1'b0);
            step(ch, 8'hD0, 16'h0005, 2'h0, 1'b0, 1'b1);
            step(ch, 8'h50, 16'h0005, 2'h0, 1'b1, 1'b1);
            step(ch, 8'h40, 16'h0005, 2'h0, 1'b0, 1'b0);
            step(ch, 8'h14, 16'h0005, 2'h2, 1'b0, 1'b1);
            step(ch, 8'h40, 16'h0005, 2'h0, 1'b0, 1'b0);
            step(ch, 8'h10, 16'h0005, 2'h2, 1'b0, 1'b0);
            step(ch, 8'h48, 16'h0005, 2'h0, 1'b0, 1'b0);
            wr(8'(8'h34 + 4 * ch), 32'h0000_0014);
            step(ch, 8'h18, 16'h0014, 2'h1, 1'b0, 1'b0);
            upd <= 1'b1;
            @(posedge clk);
            upd <= 1'b0;
            step(ch, 8'h18, 16'h0014, 2'h1, 1'b0, 1'b1);
            step(ch, 8'h40, 16'h0005, 2'h0, 1'b0, 1'b0);
            wr(8'(8'h34 + 4 * ch), 32'h0000_001E);
            step(ch, 8'h10, 16'h001E, 2'h1, 1'b0, 1'b1);
            wr(8'h18, 32'h0000_0000);
        end
        final_report();
    end
endmodule // tb
